// ---- rtl/gpio_pin_defines.svh ----
// constants for the camera pin-mode block: offsets, fields, resets, timing
// assumes 32-bit apb words and register bits numbered from the bottom (bit 0 is the lsb)
// ============================================================
// Behaviour
// - pin function codes 0 to 4 select behaviour
// - code 8 is a second level-output mode
// - lowest data bit holds pin level or output
// - trigger edge: 0 falling, 1 rising
// - strobe polarity: 0 active high, 1 low
// - strobe waits upper timing field before pulse
// - strobe pulse lasts lower timing field ticks
// - pwm low time is upper timing field
// - pwm high time is lower timing field
// - delay and pwm counters run on ticks
// - top bit reads one, feature present; the timing registers return timing data there
// - each mask bit gates one frame slot
// - pattern repeats; slot index is frame count
`ifndef GPIO_PIN_DEFINES_SVH
`define GPIO_PIN_DEFINES_SVH

// ============================================================
// register offsets (byte addresses)
`define OFF_PAT_CTRL 16'h110c
`define OFF_PIN2_CTRL 16'h1130
`define OFF_PIN2_TIMING 16'h1134
`define OFF_PIN2_PATTERN 16'h1138
`define OFF_PIN3_CTRL 16'h1140
`define OFF_PIN3_TIMING 16'h1144

// ============================================================
// field positions in little-endian bit order
`define PRESENCE_BIT 31
`define MODE_MSB 19
`define MODE_LSB 16
`define DATA_BIT 0
`define FIRST_MSB 31
`define FIRST_LSB 16
`define SECOND_MSB 15
`define SECOND_LSB 0
`define PERIOD_MSB 20
`define PERIOD_LSB 16
`define COUNT_MSB 4
`define COUNT_LSB 0

// ============================================================
// reset values and timing
`define MODE_RST 4'h0
`define TIMING_RST 32'h0000_0000
`define PCLK_HZ 25000000
`define TICK_HZ 1024000
`define TICK_DIV (`PCLK_HZ / `TICK_HZ)

`endif

// ---- rtl/gpio_pin_modes.sv ----
// camera pin-mode logic: two pins behind an apb3 register slave
// assumes frame_start is a one-cycle pulse from logic on pclk
`timescale 1ns/1ps
`include "gpio_pin_defines.svh"

// ============================================================
// one pin channel: sync, edge trigger, strobe and pwm timing
module gpio_pin_chan (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // timing and setup
    input wire logic tick,
    input wire logic frame_go,
    input wire gpio_pin_pkg::pin_cfg_t cfg,
    // pin side
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic trig,
    output logic level
);
    gpio_pin_pkg::chan_st_t st;
    gpio_pin_pkg::chan_st_t nxt;
    logic timed;
    logic pwm;

    assign timed = (cfg.mode == gpio_pin_pkg::MODE_STROBE) || pwm;
    assign pwm = (cfg.mode == gpio_pin_pkg::MODE_PWM);
    assign pin_out = st.out;
    assign pin_oe = st.oe;
    assign trig = st.trig;
    assign level = st.sync_q;

    // next state of the channel
    always_comb begin
        logic [16:0] cnt_inc;
        cnt_inc = {1'b0, st.cnt} + 17'h00001;
        nxt = st;
        // the pin is asynchronous: two flops before anyone looks
        nxt.sync_meta = pin_in;
        nxt.sync_q = st.sync_meta;
        nxt.prev_q = st.sync_q;
        nxt.trig = 1'b0;
        if (cfg.mode == gpio_pin_pkg::MODE_TRIGGER) begin
            if (cfg.data_bit) begin
                nxt.trig = st.sync_q & ~st.prev_q;
            end else begin
                nxt.trig = ~st.sync_q & st.prev_q;
            end
        end
        // timed phases; counts advance only on tick
        if (!timed) begin
            nxt.phase = gpio_pin_pkg::PH_IDLE;
            nxt.cnt = 16'h0000;
        end else begin
            case (st.phase)
                gpio_pin_pkg::PH_IDLE: begin
                    // a strobe already running ignores new frames
                    if (pwm || frame_go) begin
                        nxt.cnt = 16'h0000;
                        if (cfg.first != 16'h0000) begin
                            nxt.phase = gpio_pin_pkg::PH_FIRST;
                        end else if (cfg.second != 16'h0000) begin
                            nxt.phase = gpio_pin_pkg::PH_SECOND;
                        end
                    end
                end
                gpio_pin_pkg::PH_FIRST: begin
                    if (tick) begin
                        if (cnt_inc >= {1'b0, cfg.first}) begin
                            nxt.cnt = 16'h0000;
                            if (cfg.second != 16'h0000) begin
                                nxt.phase = gpio_pin_pkg::PH_SECOND;
                            end else if (!pwm) begin
                                nxt.phase = gpio_pin_pkg::PH_IDLE;
                            end
                        end else begin
                            nxt.cnt = cnt_inc[15:0];
                        end
                    end
                end
                gpio_pin_pkg::PH_SECOND: begin
                    if (tick) begin
                        if (cnt_inc >= {1'b0, cfg.second}) begin
                            nxt.cnt = 16'h0000;
                            if (!pwm) begin
                                nxt.phase = gpio_pin_pkg::PH_IDLE;
                            end else if (cfg.first != 16'h0000) begin
                                nxt.phase = gpio_pin_pkg::PH_FIRST;
                            end
                        end else begin
                            nxt.cnt = cnt_inc[15:0];
                        end
                    end
                end
                default: begin
                    nxt.phase = gpio_pin_pkg::PH_IDLE;
                end
            endcase
        end
        // pin drive per function code
        case (cfg.mode)
            gpio_pin_pkg::MODE_OUTPUT, gpio_pin_pkg::MODE_OUTPUT_ALT: begin
                nxt.oe = 1'b1;
                nxt.out = cfg.data_bit;
            end
            gpio_pin_pkg::MODE_STROBE, gpio_pin_pkg::MODE_PWM: begin
                nxt.oe = 1'b1;
                // second phase is the active or high part
                nxt.out = (nxt.phase == gpio_pin_pkg::PH_SECOND)
                    ^ cfg.data_bit;
            end
            default: begin
                nxt.oe = 1'b0;
                nxt.out = 1'b0;
            end
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= nxt;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_input_undriven: assert property (
        (cfg.mode == gpio_pin_pkg::MODE_INPUT) [*2] |-> !pin_oe)
        else $error("pin driven in input mode");
    a_level_drive: assert property (
        (cfg.mode == gpio_pin_pkg::MODE_OUTPUT) [*2]
        |-> pin_oe && (pin_out == $past(cfg.data_bit)))
        else $error("output level does not follow data bit");
    a_alt_output: assert property (
        (cfg.mode == gpio_pin_pkg::MODE_OUTPUT_ALT) [*2]
        |-> pin_oe && (pin_out == $past(cfg.data_bit)))
        else $error("second output mode does not drive data bit");
    a_edge_fire: assert property (
        (cfg.mode == gpio_pin_pkg::MODE_TRIGGER) && (cfg.data_bit ?
        (st.sync_q && !st.prev_q) : (!st.sync_q && st.prev_q))
        |=> trig)
        else $error("selected edge did not fire trigger");
    a_strobe_level: assert property (
        (cfg.mode == gpio_pin_pkg::MODE_STROBE) && $stable(cfg)
        && (st.phase == gpio_pin_pkg::PH_SECOND)
        |-> pin_out == !cfg.data_bit)
        else $error("strobe active level wrong");
    a_delay_end: assert property (
        (cfg.mode == gpio_pin_pkg::MODE_STROBE)
        && (st.phase == gpio_pin_pkg::PH_FIRST) && tick
        && (({1'b0, st.cnt} + 17'h00001) >= {1'b0, cfg.first})
        && (cfg.second != 16'h0000)
        |=> st.phase == gpio_pin_pkg::PH_SECOND)
        else $error("strobe did not start after delay");
    a_pulse_end: assert property (
        (cfg.mode == gpio_pin_pkg::MODE_STROBE)
        && (st.phase == gpio_pin_pkg::PH_SECOND) && tick
        && (({1'b0, st.cnt} + 17'h00001) >= {1'b0, cfg.second})
        |=> st.phase == gpio_pin_pkg::PH_IDLE)
        else $error("strobe pulse did not end");
    a_pwm_low: assert property (
        pwm && $stable(cfg) && !cfg.data_bit
        && (st.phase == gpio_pin_pkg::PH_FIRST) |-> !pin_out)
        else $error("pwm not low in low phase");
    a_pwm_high: assert property (
        pwm && $stable(cfg) && !cfg.data_bit
        && (st.phase == gpio_pin_pkg::PH_SECOND) |-> pin_out)
        else $error("pwm not high in high phase");

    c_strobe_pulse: cover property (
        (cfg.mode == gpio_pin_pkg::MODE_STROBE)
        && $rose(st.phase == gpio_pin_pkg::PH_SECOND));
    c_trigger: cover property (trig);
    c_pwm_wrap: cover property (pwm
        && $past(st.phase) == gpio_pin_pkg::PH_SECOND
        && st.phase == gpio_pin_pkg::PH_FIRST);
endmodule

// ============================================================
// top: apb3 slave, tick divider, frame pattern, two channels
module gpio_pin_modes #(
    parameter int unsigned TICK_DIV = `TICK_DIV
) (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb3 slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // frame timing from the sensor side
    input wire logic frame_start,
    // third pin
    input wire logic pin2_in,
    output logic pin2_out,
    output logic pin2_oe,
    output logic pin2_trig,
    // fourth pin
    input wire logic pin3_in,
    output logic pin3_out,
    output logic pin3_oe,
    output logic pin3_trig
);
    gpio_pin_pkg::regs_t r;
    gpio_pin_pkg::regs_t nxt;
    gpio_pin_pkg::pin_cfg_t pin2_cfg;
    gpio_pin_pkg::pin_cfg_t pin3_cfg;
    logic pin2_level;
    logic pin3_level;
    logic acc;

    // codes outside the documented set are not taken
    function automatic logic legal_mode(input logic [3:0] m);
        legal_mode = (m <= 4'h4) || (m == 4'h8);
    endfunction

    // control word in lsb-first numbering: data bit 0 is the lsb, presence bit 31 the msb
    function automatic logic [31:0] ctrl_word(
        input gpio_pin_pkg::pin_mode_t m, input logic d);
        logic [31:0] w;
        w = 32'h0000_0000; // reserved bits read zero
        w[`PRESENCE_BIT] = 1'b1;
        w[`MODE_MSB:`MODE_LSB] = m;
        w[`DATA_BIT] = d;
        return w;
    endfunction

    assign acc = psel & penable;
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    // upper field feeds the first phase, lower the second
    assign pin2_cfg = '{mode: r.pin2_mode, data_bit: r.pin2_data,
        first: r.pin2_timing[`FIRST_MSB:`FIRST_LSB],
        second: r.pin2_timing[`SECOND_MSB:`SECOND_LSB]};
    assign pin3_cfg = '{mode: r.pin3_mode, data_bit: r.pin3_data,
        first: r.pin3_timing[`FIRST_MSB:`FIRST_LSB],
        second: r.pin3_timing[`SECOND_MSB:`SECOND_LSB]};

    // next state of registers, divider, pattern and bus
    always_comb begin
        logic [5:0] cnt_inc;
        logic [31:0] rd;
        cnt_inc = {1'b0, r.count} + 6'h01;
        rd = 32'h0000_0000;
        nxt = r;
        nxt.pready = 1'b0;
        nxt.pslverr = 1'b0;
        nxt.tick = 1'b0;
        nxt.frame_go2 = 1'b0;
        nxt.frame_go3 = 1'b0;
        // tick enable from pclk
        if (r.div >= 16'(TICK_DIV - 1)) begin
            nxt.div = 16'h0000;
            nxt.tick = 1'b1;
        end else begin
            nxt.div = r.div + 16'h0001;
        end
        // slot gate uses the mask bit at 15 - count
        if (frame_start) begin
            nxt.frame_go3 = 1'b1;
            nxt.frame_go2 = (r.count <= 5'h0f)
                && r.pin2_mask[4'(5'h0f - r.count)];
            if (cnt_inc >= {1'b0, r.period}) begin
                nxt.count = 5'h00;
            end else begin
                nxt.count = cnt_inc[4:0];
            end
        end
        // first access cycle: decode, latch read data, raise pready
        if (acc && !r.pready) begin
            nxt.pready = 1'b1;
            if (paddr == `OFF_PAT_CTRL) begin
                rd[`PRESENCE_BIT] = 1'b1;
                rd[`PERIOD_MSB:`PERIOD_LSB] = r.period;
                rd[`COUNT_MSB:`COUNT_LSB] = r.count;
            end else if (paddr == `OFF_PIN2_CTRL) begin
                rd = ctrl_word(r.pin2_mode,
                    (r.pin2_mode == gpio_pin_pkg::MODE_INPUT) ?
                    pin2_level : r.pin2_data);
            end else if (paddr == `OFF_PIN2_TIMING) begin
                rd = r.pin2_timing;
            end else if (paddr == `OFF_PIN2_PATTERN) begin
                rd[`PRESENCE_BIT] = 1'b1;
                rd[15:0] = r.pin2_mask;
            end else if (paddr == `OFF_PIN3_CTRL) begin
                rd = ctrl_word(r.pin3_mode,
                    (r.pin3_mode == gpio_pin_pkg::MODE_INPUT) ?
                    pin3_level : r.pin3_data);
            end else if (paddr == `OFF_PIN3_TIMING) begin
                rd = r.pin3_timing;
            end else begin
                nxt.pslverr = 1'b1;
            end
            nxt.prdata = pwrite ? 32'h0000_0000 : rd;
        end
        // writes land on the edge that samples pready high
        if (acc && r.pready && pwrite) begin
            if (paddr == `OFF_PAT_CTRL) begin
                nxt.period = pwdata[`PERIOD_MSB:`PERIOD_LSB];
            end else if (paddr == `OFF_PIN2_CTRL) begin
                if (legal_mode(pwdata[`MODE_MSB:`MODE_LSB])) begin
                    nxt.pin2_mode = gpio_pin_pkg::pin_mode_t'(
                        pwdata[`MODE_MSB:`MODE_LSB]);
                end
                nxt.pin2_data = pwdata[`DATA_BIT];
            end else if (paddr == `OFF_PIN2_TIMING) begin
                nxt.pin2_timing = pwdata;
            end else if (paddr == `OFF_PIN2_PATTERN) begin
                nxt.pin2_mask = pwdata[15:0];
            end else if (paddr == `OFF_PIN3_CTRL) begin
                if (legal_mode(pwdata[`MODE_MSB:`MODE_LSB])) begin
                    nxt.pin3_mode = gpio_pin_pkg::pin_mode_t'(
                        pwdata[`MODE_MSB:`MODE_LSB]);
                end
                nxt.pin3_data = pwdata[`DATA_BIT];
            end else if (paddr == `OFF_PIN3_TIMING) begin
                nxt.pin3_timing = pwdata;
            end
        end
    end

    // all-zero reset leaves both pins in input mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    gpio_pin_chan u_pin2 (
        .pclk(pclk),
        .presetn(presetn),
        .tick(r.tick),
        .frame_go(r.frame_go2),
        .cfg(pin2_cfg),
        .pin_in(pin2_in),
        .pin_out(pin2_out),
        .pin_oe(pin2_oe),
        .trig(pin2_trig),
        .level(pin2_level)
    );

    // the fourth pin's mask is not in this block, so every frame fires
    gpio_pin_chan u_pin3 (
        .pclk(pclk),
        .presetn(presetn),
        .tick(r.tick),
        .frame_go(r.frame_go3),
        .cfg(pin3_cfg),
        .pin_in(pin3_in),
        .pin_out(pin3_out),
        .pin_oe(pin3_oe),
        .trig(pin3_trig),
        .level(pin3_level)
    );

    default clocking tcb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_count_wrap: assert property (
        frame_start && (({1'b0, r.count} + 6'h01) >= {1'b0, r.period})
        |=> r.count == 5'h00)
        else $error("frame count did not wrap at period");
    a_slot_gate: assert property (
        frame_start && (r.count <= 5'h0f)
        && !r.pin2_mask[4'(5'h0f - r.count)] |=> !r.frame_go2)
        else $error("masked slot still fired strobe");
    a_presence_read: assert property (
        acc && !r.pready && !pwrite && (paddr == `OFF_PIN3_CTRL)
        |=> pready && prdata[`PRESENCE_BIT] && (prdata[30:20] == 11'h000))
        else $error("presence bit or reserved bits wrong");
    a_tick_pulse: assert property (
        r.tick && (TICK_DIV > 1) |=> !r.tick)
        else $error("tick longer than one cycle");
    a_pready_single: assert property (
        pready |=> !pready)
        else $error("pready held more than one cycle");
    c_strobe_frame: cover property (frame_start && r.period > 5'h01);
    c_bad_addr: cover property (pready && pslverr);
endmodule

// ---- rtl/gpio_pin_pkg.sv ----
// types shared by the camera pin-mode block
// assumes the defines header supplies offsets, fields, resets and timing
package gpio_pin_pkg;

    // pin function codes
    typedef enum logic [3:0] {
        MODE_INPUT = 4'h0,
        MODE_OUTPUT = 4'h1,
        MODE_TRIGGER = 4'h2,
        MODE_STROBE = 4'h3,
        MODE_PWM = 4'h4,
        MODE_OUTPUT_ALT = 4'h8
    } pin_mode_t;

    // timed phase: strobe delay/pulse or pwm low/high
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_FIRST = 2'b01,
        PH_SECOND = 2'b10
    } phase_t;

    typedef struct packed {
        pin_mode_t mode;
        logic data_bit;
        logic [15:0] first;
        logic [15:0] second;
    } pin_cfg_t;

    typedef struct packed {
        logic sync_meta;
        logic sync_q;
        logic prev_q;
        phase_t phase;
        logic [15:0] cnt;
        logic out;
        logic oe;
        logic trig;
    } chan_st_t;

    typedef struct packed {
        pin_mode_t pin2_mode;
        logic pin2_data;
        pin_mode_t pin3_mode;
        logic pin3_data;
        logic [31:0] pin2_timing;
        logic [31:0] pin3_timing;
        logic [15:0] pin2_mask;
        logic [4:0] period;
        logic [4:0] count;
        logic [15:0] div;
        logic tick;
        logic frame_go2;
        logic frame_go3;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } regs_t;

endpackage

// ---- sim/camera_gpio_pin_modes_test.sv ----
// self-checking bench for the camera pin-mode block
// assumes TICK_DIV of 2 so timed counts stay short
`timescale 1ns/1ps
`include "gpio_pin_defines.svh"

module camera_gpio_pin_modes_test;
    logic pclk, presetn, psel, penable, pwrite, frame_start;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic pready, pslverr;
    logic pin2_in, pin2_out, pin2_oe, pin2_trig;
    logic pin3_in, pin3_out, pin3_oe, pin3_trig;
    logic drv2, drv3, act2, act3, clr;
    logic [15:0] cyc2, cyc3;
    logic [7:0] pul2, pul3;
    int error_cnt = 0;
    int total_checks = 0;
    int trig_cnt = 0;
    int seed = 67;
    int n;
    logic [32:0] exp_q[$];

    // ============================================================
    // clock, design and partners
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    gpio_pin_modes #(.TICK_DIV(2)) i_gpio_pin_modes (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frame_start(frame_start),
        .pin2_in(pin2_in), .pin2_out(pin2_out), .pin2_oe(pin2_oe),
        .pin2_trig(pin2_trig), .pin3_in(pin3_in), .pin3_out(pin3_out),
        .pin3_oe(pin3_oe), .pin3_trig(pin3_trig));
    pin_partner i_pin_partner2 (.pclk(pclk), .drive_lvl(drv2),
        .act_lvl(act2), .clr(clr), .pin_out(pin2_out), .pin_oe(pin2_oe),
        .pin_in(pin2_in), .act_cycles(cyc2), .pulses(pul2));
    pin_partner i_pin_partner3 (.pclk(pclk), .drive_lvl(drv3),
        .act_lvl(act3), .clr(clr), .pin_out(pin3_out), .pin_oe(pin3_oe),
        .pin_in(pin3_in), .act_cycles(cyc3), .pulses(pul3));

    // ============================================================
    // compare, verdict and bus tasks
    task automatic check(input string what, input logic [32:0] seen,
                         input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // expectation is {pslverr, prdata}; request held until pready
    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [31:0] wd, input logic [32:0] exp);
        exp_q.push_back(exp);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask

    task automatic frame();
        @(posedge pclk);
        frame_start <= 1'b1;
        @(posedge pclk);
        frame_start <= 1'b0;
    endtask

    task automatic clear_meters();
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        @(posedge pclk);
    endtask

    // length of the current run of pin3_out at lvl, bounded
    task automatic run(input logic lvl, output int len);
        len = 0;
        while (pin3_out === lvl && len < 100) begin
            @(posedge pclk);
            len++;
        end
    endtask

    // ============================================================
    // answer monitor: oldest note against each bus answer
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("spare answer", 33'h1, 33'h0);
            end else begin
                check("apb answer", {pslverr, prdata}, exp_q.pop_front());
            end
        end
        if (pin2_trig === 1'b1) begin
            trig_cnt++;
        end
    end

    // watchdog: the whole sequence needs far fewer cycles
    initial begin
        repeat (20000) @(posedge pclk);
        check("watchdog", 33'h1, 33'h0);
        tally_and_finish();
    end

    // ============================================================
    // main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, frame_start} = 4'h0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        {drv2, drv3, act2, act3, clr} = 5'h01;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        clr <= 1'b0;
        rd(`OFF_PIN3_CTRL, 32'h8000_0000);
        rd(`OFF_PIN3_TIMING, 32'h0000_0000);
        rd(`OFF_PIN2_PATTERN, 32'h8000_0000);
        apb(1'b0, 16'h1150, 32'h0, 33'h1_0000_0000);
        for (int i = 0; i < 2; i++) begin
            v = $random(seed);
            wr(i ? `OFF_PIN3_TIMING : `OFF_PIN2_TIMING, v);
            rd(i ? `OFF_PIN3_TIMING : `OFF_PIN2_TIMING, v);
        end
        wr(`OFF_PIN3_CTRL, 32'h7ff1_fffe);
        rd(`OFF_PIN3_CTRL, 32'h8001_0000);
        wr(`OFF_PIN3_CTRL, 32'h000f_0001);
        rd(`OFF_PIN3_CTRL, 32'h8001_0001);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            wr(`OFF_PIN3_CTRL, {12'h0, i[1] ? 4'h8 : 4'h1, 15'h0, i[0]});
            repeat (3) @(posedge pclk);
            check("pin3 drive", {31'h0, pin3_oe, pin3_out}, {32'h1, i[0]});
        end
        wr(`OFF_PIN3_CTRL, 32'h0000_0000);
        drv3 <= 1'b1;
        repeat (5) @(posedge pclk);
        check("pin3 release", {32'h0, pin3_oe}, 33'h0);
        rd(`OFF_PIN3_CTRL, 32'h8000_0001);
        $display("test level modes done");
        for (int d = 0; d < 2; d++) begin
            wr(`OFF_PIN2_CTRL, {12'h0, 4'h2, 15'h0, d[0]});
            repeat (4) @(posedge pclk);
            trig_cnt = 0;
            drv2 <= 1'b1;
            repeat (8) @(posedge pclk);
            check("rise trigger", 33'(trig_cnt), 33'(d));
            drv2 <= 1'b0;
            repeat (8) @(posedge pclk);
            check("fall trigger", 33'(trig_cnt), 33'h1);
        end
        $display("test trigger done");
        wr(`OFF_PIN3_TIMING, {16'd2, 16'd3});
        for (int d = 0; d < 2; d++) begin
            act3 <= ~d[0];
            wr(`OFF_PIN3_CTRL, {12'h0, 4'h3, 15'h0, d[0]});
            repeat (4) @(posedge pclk);
            clear_meters();
            frame();
            repeat (2) @(posedge pclk);
            check("strobe early", {25'h0, pul3}, 33'h0);
            repeat (30) @(posedge pclk);
            check("strobe width", {17'h0, cyc3}, 33'd6);
            check("strobe count", {25'h0, pul3}, 33'd1);
        end
        $display("test strobe done");
        wr(`OFF_PAT_CTRL, 32'h0003_0000);
        rd(`OFF_PAT_CTRL, 32'h8003_0000);
        wr(`OFF_PIN2_PATTERN, 32'hffff_2000);
        rd(`OFF_PIN2_PATTERN, 32'h8000_2000);
        wr(`OFF_PIN2_TIMING, 32'h0000_0001);
        wr(`OFF_PIN2_CTRL, 32'h0003_0000);
        act2 <= 1'b1;
        clear_meters();
        repeat (6) begin
            frame();
            repeat (12) @(posedge pclk);
        end
        check("pattern strobes", {25'h0, pul2}, 33'd2);
        rd(`OFF_PAT_CTRL, 32'h8003_0000);
        $display("test pattern done");
        wr(`OFF_PIN3_CTRL, 32'h0004_0000);
        run(1'b1, n);
        run(1'b0, n);
        run(1'b1, n);
        check("pwm high", 33'(n), 33'd6);
        run(1'b0, n);
        check("pwm low", 33'(n), 33'd4);
        $display("test pwm done");
        repeat (4) @(posedge pclk);
        check("open answers", 33'(exp_q.size()), 33'h0);
        tally_and_finish();
    end
endmodule

// ---- sim/pin_partner.sv ----
// far side of one camera pin: trigger source plus strobe load
// assumes the block drives the wire whenever pin_oe is high
`timescale 1ns/1ps

// ============================================================
// pin wire and load meter
module pin_partner (
    // clock
    input wire logic pclk,
    // source level, active level of the load, meter clear
    input wire logic drive_lvl,
    input wire logic act_lvl,
    input wire logic clr,
    // pin
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_in,
    // load meter
    output logic [15:0] act_cycles,
    output logic [7:0] pulses
);
    logic was_act;
    logic is_act;

    // the block owns the wire while it drives, else the source does
    assign pin_in = pin_oe ? pin_out : drive_lvl;
    assign is_act = pin_oe && (pin_in == act_lvl);

    // load counts active cycles and pulse starts; clear before use
    always @(posedge pclk) begin
        if (clr) begin
            act_cycles <= 16'h0000;
            pulses <= 8'h00;
        end else begin
            act_cycles <= act_cycles + 16'(is_act);
            pulses <= pulses + 8'(is_act && !was_act);
        end
        was_act <= is_act;
    end
endmodule
